/* core/plldiv_top.sv */
/*
 pll reference divider, prescaler, swallow and main counters and the
 distribution source select, with an 8-bit register port.
 assumes the divider inputs are already synchronous to i_clk and at
 most toggle once per two clock cycles.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "plldiv_regs.svh"

module plldiv_top
   import plldiv_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire plldiv_bus_t i_bus,
   input wire logic i_reference_clock_input,
   input wire logic i_oscillator_feedback_input,
   input wire logic i_alternate_distribution_input,
   output logic [7:0] o_rdata,
   output logic o_ref_div_pulse,
   output logic o_fb_div_pulse,
   output logic o_dist_clk
);

   // ----------------------------------------------------------------
   // prescaler decode
   // ----------------------------------------------------------------
   function automatic logic [5:0] plldiv_p(input logic [2:0] code);
      logic [5:0] p;
      p = 6'h01;
      case (code)
         // [RL5] fixed ratios
         3'b000: p = 6'h01;
         3'b001: p = 6'h02;
         3'b111: p = 6'h03;
         // [RL6] dual modulus base
         3'b010: p = 6'h02;
         3'b011: p = 6'h04;
         3'b100: p = 6'h08;
         3'b101: p = 6'h10;
         3'b110: p = 6'h20;
         default: p = 6'h01;
      endcase
      return p;
   endfunction : plldiv_p

   function automatic logic plldiv_dual(input logic [2:0] code);
      return (code != 3'b000) && (code != 3'b001) && (code != 3'b111);
   endfunction : plldiv_dual

   plldiv_state_t st_q;
   plldiv_state_t st_d;

   logic ref_edge;
   logic osc_edge;
   logic pre_done;
   logic [12:0] main_eff;
   logic [5:0] sw_next;
   logic next_dual;

   assign ref_edge = i_reference_clock_input & ~st_q.ref_prev;
   // [RL16] feedback only from oscillator
   assign osc_edge = i_oscillator_feedback_input & ~st_q.osc_prev;
   assign pre_done = osc_edge && (st_q.pre_cnt <= 6'h01);
   // [RL9] bypass gives divide by one
   assign main_eff = st_q.bypass ? 13'h0001 : st_q.main;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      sw_next = st_q.sw_cnt;
      next_dual = 1'b0;
      st_d.ref_pulse = 1'b0;
      st_d.fb_pulse = 1'b0;
      st_d.rdata = 8'h00;
      st_d.ref_prev = i_reference_clock_input;
      st_d.osc_prev = i_oscillator_feedback_input;

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            `PLLDIV_OFS_SWALLOW: st_d.swallow = i_bus.wdata[5:0];
            `PLLDIV_OFS_MAIN_HI: st_d.main[12:8] = i_bus.wdata[4:0];
            `PLLDIV_OFS_MAIN_LO: st_d.main[7:0] = i_bus.wdata;
            `PLLDIV_OFS_CNT_RST: begin
               st_d.rst_all = i_bus.wdata[`PLLDIV_BIT_RST_ALL];
               st_d.rst_ab = i_bus.wdata[`PLLDIV_BIT_RST_AB];
            end
            `PLLDIV_OFS_PRESC: begin
               st_d.presc_code =
                  i_bus.wdata[`PLLDIV_PRESC_MSB:`PLLDIV_PRESC_LSB];
               st_d.bypass = i_bus.wdata[`PLLDIV_BIT_BYPASS];
            end
            // [RL2] six upper and eight lower bits
            `PLLDIV_OFS_REF_HI: st_d.ref_ratio[13:8] = i_bus.wdata[5:0];
            `PLLDIV_OFS_REF_LO: st_d.ref_ratio[7:0] = i_bus.wdata;
            `PLLDIV_OFS_DIST_SEL:
               st_d.dist_sel = i_bus.wdata[`PLLDIV_BIT_DIST_SEL];
            default: st_d.rdata = 8'h00;
         endcase
      end

      // register reads, answered next cycle
      if (i_bus.rd) begin
         case (i_bus.addr)
            `PLLDIV_OFS_SWALLOW: st_d.rdata = {2'b00, st_q.swallow};
            `PLLDIV_OFS_MAIN_HI: st_d.rdata = {3'b000, st_q.main[12:8]};
            `PLLDIV_OFS_MAIN_LO: st_d.rdata = st_q.main[7:0];
            `PLLDIV_OFS_CNT_RST:
               st_d.rdata = {6'h00, st_q.rst_ab, st_q.rst_all};
            `PLLDIV_OFS_PRESC:
               st_d.rdata = {1'b0, st_q.bypass, 1'b0, st_q.presc_code,
                             2'b00};
            `PLLDIV_OFS_REF_HI: st_d.rdata = {2'b00, st_q.ref_ratio[13:8]};
            `PLLDIV_OFS_REF_LO: st_d.rdata = st_q.ref_ratio[7:0];
            `PLLDIV_OFS_DIST_SEL: st_d.rdata = {7'h00, st_q.dist_sel};
            // [RL10] flags main count below range
            `PLLDIV_OFS_STATUS:
               st_d.rdata = {5'h00,
                             (!st_q.bypass &&
                              st_q.main < `PLLDIV_MAIN_MIN),
                             plldiv_dual(st_q.cur_code),
                             st_q.rst_all | st_q.rst_ab};
            default: st_d.rdata = 8'h00;
         endcase
      end

      // -------------------------------------------------------------
      // reference divider
      // -------------------------------------------------------------
      // [RL11] shared bit holds reference counter
      if (st_q.rst_all) begin
         st_d.ref_cnt = 14'h0000;
      end else if (ref_edge) begin
         // [RL1] 14-bit down counter, [RL20] reload at terminal
         if (st_q.ref_cnt <= 14'h0001) begin
            // [RL3] pulse to detector input
            st_d.ref_pulse = 1'b1;
            // [RL2] zero ratio divides by one
            st_d.ref_cnt = (st_q.ref_ratio == 14'h0000) ?
                           14'h0001 : st_q.ref_ratio;
         end else begin
            st_d.ref_cnt = st_q.ref_cnt - 14'h0001;
         end
      end

      // -------------------------------------------------------------
      // feedback divider
      // -------------------------------------------------------------
      // [RL11] [RL12] hold swallow, main and prescaler
      if (st_q.rst_all || st_q.rst_ab) begin
         st_d.pre_cnt = 6'h00;
         st_d.sw_cnt = 6'h00;
         st_d.main_cnt = 13'h0000;
         st_d.cur_code = st_q.presc_code;
      end else if (osc_edge) begin
         if (!pre_done) begin
            st_d.pre_cnt = st_q.pre_cnt - 6'h01;
         end else begin
            // [RL4] prescaler output clocks main counter
            next_dual = plldiv_dual(st_q.cur_code);
            if (st_q.main_cnt <= 13'h0001) begin
               // [RL20] ratios latched at reload
               st_d.cur_code = st_q.presc_code;
               st_d.main_cnt = main_eff;
               next_dual = plldiv_dual(st_q.presc_code);
               // [RL7] [RL14] swallow ignored in fixed mode
               sw_next = next_dual ? st_q.swallow : 6'h00;
               // [RL10] zero main count stalls output
               st_d.fb_pulse = (st_q.main_cnt != 13'h0000) ||
                               (main_eff != 13'h0000);
               // [RL18] feedback pulse to detector
               if (main_eff == 13'h0000) begin
                  st_d.fb_pulse = 1'b0;
               end
            end else begin
               st_d.main_cnt = st_q.main_cnt - 13'h0001;
               sw_next = (st_q.sw_cnt != 6'h00) ?
                         st_q.sw_cnt - 6'h01 : 6'h00;
            end
            st_d.sw_cnt = sw_next;
            // [RL19] P+1 while swallow remains, else P
            // [RL13] [RL15] gives P*B+A, down to one
            st_d.pre_cnt = plldiv_p(st_d.cur_code) +
                           ((next_dual && sw_next != 6'h00) ?
                            6'h01 : 6'h00);
         end
      end

      // -------------------------------------------------------------
      // distribution source
      // -------------------------------------------------------------
      // [RL17] cleared selects oscillator input
      st_d.dist_out = st_q.dist_sel ? i_alternate_distribution_input
                                    : i_oscillator_feedback_input;

      if (!i_ce) begin
         st_d = st_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= '0;
         st_q.dist_sel <= `PLLDIV_RST_DIST_SEL;
         st_q.main <= `PLLDIV_RST_MAIN;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rdata = st_q.rdata;
   assign o_ref_div_pulse = st_q.ref_pulse;
   assign o_fb_div_pulse = st_q.fb_pulse;
   assign o_dist_clk = st_q.dist_out;

endmodule : plldiv_top

/* include/plldiv_regs.svh */
/*
 register offsets, field positions and reset values of the pll
 reference and feedback dividers; assumes an 8-bit register port.
*/
// Contract
// [RL1] reference divider is a 14-bit counter
// [RL2] reference ratio 1..16383, zero divides by one
// [RL3] reference output feeds phase detector input
// [RL4] feedback: 3-bit prescaler, 6-bit swallow, 13-bit main
// [RL5] fixed codes: 000 /1, 001 /2, 111 /3
// [RL6] codes 010..110 dual modulus 2/3..32/33
// [RL7] fixed mode: swallow unused, main maybe bypassed
// [RL8] oscillator below 600/1000/1600 MHz per modulus
// [RL9] bypass bit makes main divide by one
// [RL10] main range 3..8191, reset value 0 invalid
// [RL11] shared bit resets reference, swallow, main counters
// [RL12] separate reset bit for swallow and main
// [RL13] dual mode total division is P*B+A
// [RL14] fixed mode total division is P*B
// [RL15] total division reaches down to one
// [RL16] only oscillator input feeds feedback divider
// [RL17] select bit cleared routes oscillator to distribution
// [RL18] detector compares reference and feedback outputs
// [RL19] divide P+1 until swallow expires, then P
// [RL20] one pulse per count, new ratio at reload
`ifndef PLLDIV_REGS_SVH
`define PLLDIV_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define PLLDIV_OFS_SWALLOW 8'h04
`define PLLDIV_OFS_MAIN_HI 8'h05
`define PLLDIV_OFS_MAIN_LO 8'h06
`define PLLDIV_OFS_CNT_RST 8'h09
`define PLLDIV_OFS_PRESC 8'h0a
`define PLLDIV_OFS_REF_HI 8'h0b
`define PLLDIV_OFS_REF_LO 8'h0c
`define PLLDIV_OFS_DIST_SEL 8'h45
`define PLLDIV_OFS_STATUS 8'h50

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PLLDIV_BIT_RST_ALL 0
`define PLLDIV_BIT_RST_AB 1
`define PLLDIV_BIT_BYPASS 6
`define PLLDIV_PRESC_LSB 2
`define PLLDIV_PRESC_MSB 4
`define PLLDIV_BIT_DIST_SEL 0

// ----------------------------------------------------------------
// reset values and main minimum
// ----------------------------------------------------------------
`define PLLDIV_RST_DIST_SEL 1'b1
`define PLLDIV_RST_MAIN 13'h0000
`define PLLDIV_MAIN_MIN 13'h0003

`endif

/* include/plldiv_pkg.sv */
/*
 types of the pll reference and feedback dividers;
 assumes plldiv_regs.svh is included by the user of each type.
*/
package plldiv_pkg;

   // -------------------------------------------------------------
   // register port request
   // -------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } plldiv_bus_t;

   // -------------------------------------------------------------
   // whole module state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [13:0] ref_ratio;
      logic [5:0] swallow;
      logic [12:0] main;
      logic [2:0] presc_code;
      logic bypass;
      logic rst_all;
      logic rst_ab;
      logic dist_sel;
      logic [13:0] ref_cnt;
      logic [5:0] pre_cnt;
      logic [5:0] sw_cnt;
      logic [12:0] main_cnt;
      logic [2:0] cur_code;
      logic ref_prev;
      logic osc_prev;
      logic ref_pulse;
      logic fb_pulse;
      logic dist_out;
      logic [7:0] rdata;
   } plldiv_state_t;

endpackage : plldiv_pkg

/* dv/plldiv_top_assertions.sv */
/*
 port assertions of plldiv_top.
 assumes inputs change just after rising edges of i_clk.
*/
`timescale 1ns/100ps
module plldiv_assertions
   import plldiv_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire plldiv_bus_t i_bus,
   input wire logic i_reference_clock_input,
   input wire logic i_oscillator_feedback_input,
   input wire logic i_alternate_distribution_input,
   input wire logic [7:0] o_rdata,
   input wire logic o_ref_div_pulse,
   input wire logic o_fb_div_pulse,
   input wire logic o_dist_clk
);
   logic sel_q;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   // shadow of the source select bit
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn)
         sel_q <= 1'b1;
      else if (i_ce && i_bus.wr && i_bus.addr == 8'h45)
         sel_q <= i_bus.wdata[0];
   end
   property p_cause(logic p, logic s);
      p |-> ($past(s) && !$past(s, 2)) || ($past(s, 2) && !$past(s, 3))
         || ($past(s, 3) && !$past(s, 4));
   endproperty
   property p_one(logic p);
      p && i_ce |=> !p;
   endproperty
   a_ref_cause: assert property (
      p_cause(o_ref_div_pulse, i_reference_clock_input))
      else $error("ref pulse without edge");
   a_fb_cause: assert property (
      p_cause(o_fb_div_pulse, i_oscillator_feedback_input))
      else $error("fb pulse without edge");
   a_ref_single: assert property (p_one(o_ref_div_pulse))
      else $error("ref pulse too long");
   a_fb_single: assert property (p_one(o_fb_div_pulse))
      else $error("fb pulse too long");
   a_dist_follow: assert property ($past(i_ce) && $past(i_resetn) |->
      o_dist_clk == ($past(sel_q) ? $past(i_alternate_distribution_input)
      : $past(i_oscillator_feedback_input)))
      else $error("wrong distribution source");
   a_sel_read: assert property ($past(i_ce && i_bus.rd) &&
      $past(i_bus.addr) == 8'h45 |-> o_rdata[0] == $past(sel_q))
      else $error("select read wrong");
   a_unmapped_zero: assert property ($past(i_ce && i_bus.rd) &&
      !($past(i_bus.addr) inside {8'h04, 8'h05, 8'h06, 8'h09, 8'h0a,
      8'h0b, 8'h0c, 8'h45, 8'h50}) |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ce_freeze: assert property (!$past(i_ce) |-> $stable(o_rdata) &&
      $stable(o_ref_div_pulse) && $stable(o_fb_div_pulse))
      else $error("outputs moved while frozen");
   c_fb: cover property (o_fb_div_pulse);
   c_ref: cover property (o_ref_div_pulse);
   c_hold: cover property (!i_ce ##1 i_ce);
endmodule : plldiv_assertions
bind plldiv_top plldiv_assertions u_chk (.i_clk(i_clk),
   .i_resetn(i_resetn), .i_ce(i_ce), .i_bus(i_bus),
   .i_reference_clock_input(i_reference_clock_input),
   .i_oscillator_feedback_input(i_oscillator_feedback_input),
   .i_alternate_distribution_input(i_alternate_distribution_input),
   .o_rdata(o_rdata), .o_ref_div_pulse(o_ref_div_pulse),
   .o_fb_div_pulse(o_fb_div_pulse), .o_dist_clk(o_dist_clk));

/* dv/plldiv_src_model.sv */
/*
 reference source and oscillator model.
 assumes callers start a burst just after a rising edge.
*/
`timescale 1ns/100ps
module plldiv_src_model (
   input wire logic i_clk,
   output logic o_ref,
   output logic o_osc,
   output logic o_alt
);
   initial begin
      o_ref = 1'b0;
      o_osc = 1'b0;
      o_alt = 1'b0;
   end
   always @(posedge i_clk)
      o_alt <= ~o_alt;
   task burst(input int n, input int h);
      fork
         repeat (n) begin
            repeat (2) @(posedge i_clk);
            o_ref <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_ref <= 1'b0;
         end
         repeat (n) begin
            repeat (h) @(posedge i_clk);
            o_osc <= 1'b1;
            repeat (h) @(posedge i_clk);
            o_osc <= 1'b0;
         end
      join
   endtask : burst
endmodule : plldiv_src_model

/* dv/tb.sv */
/*
 self-checking testbench of plldiv_top.
 assumes plldiv_src_model and the bound checker.
*/
`timescale 1ns/100ps
module tb;
   import plldiv_pkg::*;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_ce = 1'b1;
   plldiv_bus_t i_bus = '0;
   logic s_ref, s_osc, s_alt, ref_p, fb_p, dclk;
   logic [7:0] rdata;
   logic [7:0] mir [256] = '{default: 8'h00};
   logic [7:0] adr [9] = '{8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h0b,
      8'h0c, 8'h45, 8'h33};
   int t [12][6] = '{'{0,0,0,1,0,0}, '{1,0,0,1,1,0}, '{7,5,3,0,5,0},
      '{1,2,3,0,16383,0}, '{2,1,3,0,3,0}, '{3,1,3,0,2,0},
      '{4,2,3,0,1,0}, '{5,0,3,0,7,0}, '{6,2,3,0,4,0},
      '{2,0,0,0,2,0}, '{4,1,3,0,2,1}, '{4,1,3,0,2,2}};
   int fail_count = 0;
   int checks = 0;
   int nref = 0;
   int nfb = 0;
   always #5 i_clk = ~i_clk;
   plldiv_src_model u_src (.i_clk(i_clk), .o_ref(s_ref), .o_osc(s_osc),
      .o_alt(s_alt));
   plldiv_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
      .i_bus(i_bus), .i_reference_clock_input(s_ref),
      .i_oscillator_feedback_input(s_osc),
      .i_alternate_distribution_input(s_alt), .o_rdata(rdata),
      .o_ref_div_pulse(ref_p), .o_fb_div_pulse(fb_p), .o_dist_clk(dclk));
   always @(posedge i_clk) begin
      nref += int'(ref_p === 1'b1);
      nfb += int'(fb_p === 1'b1);
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %0d exp %0d", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] ad, input logic [7:0] d);
      i_bus <= '{1'b1, 1'b0, ad, d};
      if (ad != 8'h33)
         mir[ad] = d;
      @(posedge i_clk);
   endtask : wr
   task rd_chk(input logic [7:0] ad);
      i_bus <= '{1'b0, 1'b1, ad, 8'h00};
      @(posedge i_clk);
      i_bus <= '0;
      @(negedge i_clk);
      chk(16'(rdata), 16'(mir[ad]));
      @(posedge i_clk);
   endtask : rd_chk
   task automatic run(input int c, input int a, input int b, input int y,
      input int q, input int z);
      int p;
      int n;
      int e;
      p = c == 7 ? 3 : c < 2 ? c + 1 : 1 << (c - 1);
      n = (y ? 1 : b) * p + (c inside {[2:6]} ? a : 0);
      e = 2 * n + 1;
      wr(8'h09, 8'h01);
      wr(8'h04, 8'(a));
      wr(8'h05, 8'(b >> 8));
      wr(8'h06, 8'(b));
      wr(8'h0a, 8'(c << 2 | y << 6));
      wr(8'h0b, 8'(q >> 8));
      wr(8'h0c, 8'(q));
      wr(8'h45, 8'(c & 1));
      wr(8'h33, 8'hff);
      wr(8'h09, 8'(z));
      i_bus <= '0;
      @(posedge i_clk);
      nref = 0;
      nfb = 0;
      u_src.burst(e, 2 + $urandom_range(2));
      repeat (8) @(posedge i_clk);
      q = q == 0 ? 1 : q;
      chk(16'(nref), 16'(z[0] ? 0 : 1 + (e - 1) / q));
      chk(16'(nfb), 16'(z ? 0 : n ? 1 + (e - 1) / n : 0));
      mir[8'h50] = {5'h00, 1'(y == 0 && b < 3), 1'(c inside {[2:6]}),
         1'(z != 0)};
      rd_chk(8'h50);
   endtask : run
   task complete_run();
      $display("mismatches %0d comparisons %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   initial begin
      int rb;
      void'($urandom(32'h8cdd_b3ac));
      mir[8'h45] = 8'h01;
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      foreach (adr[k]) rd_chk(adr[k]);
      foreach (t[k]) run(t[k][0], t[k][1], t[k][2], t[k][3], t[k][4],
         t[k][5]);
      rb = 3 + $urandom_range(3);
      run($urandom_range(7), $urandom_range(rb - 1), rb, 0,
         1 + $urandom_range(9), 0);
      i_ce <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_ce <= 1'b1;
      foreach (adr[k]) rd_chk(adr[k]);
      complete_run();
   end
   initial begin
      #500_000;
      fail_count++;
      complete_run();
   end
endmodule : tb
